// *** rtl/acf_flag_bank.sv ***
// Purpose: sixteen conversion done flags with set and clear priority
// Assumes: set and clear vectors are computed by the caller
// Notes:   sequence clear beats set, set beats bus clear
`timescale 1ns/1ps
`default_nettype none
module acf_flag_bank
  import acf_pkg::*;
(
  input  wire logic          ref_clk_in,
  input  wire logic          srst_in,
  input  wire acf_flag_ctl_t flag_ctl_in,
  output logic [15:0]        flags_out
);
  logic [15:0] next_flags;

  always_comb begin
    if (flag_ctl_in.seq_clr) begin
      next_flags = RST_REG;
    end else begin
      next_flags = (flags_out & ~flag_ctl_in.bus_clr)
                 | flag_ctl_in.set;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      flags_out <= RST_REG;
    end else begin
      flags_out <= next_flags;
    end
  end
endmodule
`default_nettype wire

// *** rtl/acf_pkg.sv ***
// Purpose: shared constants and types of the conversion flag block
// Assumes: register bus carries 32-bit words, registers are 16 bits
// Notes:   bus byte address is four times the register index
package acf_pkg;
  localparam int unsigned SLOTS    = 16;
  localparam int unsigned CONV_W   = 12;
  localparam int unsigned REG_W    = 16;
  localparam int unsigned IDX_W    = 6;

  // register indices
  localparam logic [5:0] IDX_CTL    = 6'h01;
  localparam logic [5:0] IDX_SEQ    = 6'h05;
  localparam logic [5:0] IDX_SLOT_COMPARE_ENABLE   = 6'h08;
  localparam logic [5:0] IDX_FLAGS  = 6'h0B;
  localparam logic [5:0] IDX_DIEN   = 6'h0C;
  localparam logic [5:0] IDX_COMPARE_HIGHER_SELECT  = 6'h0E;
  localparam logic [5:0] IDX_RES0   = 6'h10;
  localparam logic [5:0] IDX_RES15  = 6'h2E;
  localparam logic [5:0] IDX_ISTAT  = 6'h30;
  localparam logic [5:0] IDX_IMASK  = 6'h31;

  // field positions
  localparam int unsigned CTL_FFC_BIT  = 0;
  localparam int unsigned CTL_CIE_BIT  = 1;
  localparam logic [15:0] CTL_MASK     = 16'h0003;
  localparam int unsigned IRQ_CMP_BIT  = 0;
  localparam int unsigned IRQ_DONE_BIT = 1;
  localparam logic [15:0] IRQ_MASK_W   = 16'h0003;
  localparam int unsigned JUST_SHIFT   = 4;

  // reset values
  localparam logic [15:0] RST_REG   = 16'h0000;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;
  localparam logic        RST_WAIT  = 1'b1;

  typedef struct packed {
    logic        valid;
    logic [3:0]  slot;
    logic [11:0] value;
  } acf_conv_t;

  typedef struct packed {
    logic [15:0] set;
    logic [15:0] bus_clr;
    logic        seq_clr;
  } acf_flag_ctl_t;
endpackage

// *** rtl/acf_top.sv ***
// Purpose: conversion done flags, automatic compare, input enables
// Assumes: converter core presents one finished conversion per pulse
// Notes:   one wait state on every bus access
`timescale 1ns/1ps
`default_nettype none
module acf_top
  import acf_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        srst_in,
  input  wire logic [7:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire acf_conv_t   conv_in,
  input  wire logic        right_justify_in,
  output logic             seq_start_out,
  output logic             seq_abort_out,
  output logic [15:0]      conversion_done_flags_out,
  output logic [15:0]      digital_input_buffer_enable_out,
  output logic             irq_out
);
  function automatic logic [15:0] onehot16(input logic [3:0] s);
    onehot16 = 16'h0001 << s;
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] wd,
                                          input logic [3:0]  be);
    merge16 = {be[1] ? wd[15:8] : old[15:8],
               be[0] ? wd[7:0]  : old[7:0]};
  endfunction

  function automatic logic is_res(input logic [5:0] i);
    is_res = (i >= IDX_RES0) && (i <= IDX_RES15) && !i[0];
  endfunction

  function automatic logic [3:0] res_slot(input logic [5:0] i);
    logic [5:0] d;
    d = i - IDX_RES0;
    res_slot = d[4:1];
  endfunction

  // bus state
  logic        wait_q;
  logic        next_wait;
  logic [31:0] next_rdata;
  logic        next_start;
  logic        next_abort;

  // registers
  logic [15:0] ctl_q;
  logic [15:0] slot_compare_enable_q;
  logic [15:0] compare_higher_select_q;
  logic [15:0] stat_q;
  logic [15:0] mask_q;
  logic [15:0] res_q [SLOTS];
  logic [15:0] next_ctl;
  logic [15:0] next_slot_compare_enable;
  logic [15:0] next_compare_higher_select;
  logic [15:0] next_dien;
  logic [15:0] next_stat;
  logic [15:0] next_mask;
  logic [15:0] next_res [SLOTS];
  logic        next_irq;

  // decode
  logic [5:0]  idx;
  logic        req;
  logic        wr_go;
  logic        rd_go;
  logic        res_sel;
  logic [3:0]  rs;
  logic [15:0] wd16;
  logic        ffc;
  logic        cie;

  // compare path
  logic [3:0]    cslot;
  logic [15:0]   stored;
  logic [11:0]   stored12;
  logic          cmp_on;
  logic          hit;
  logic [15:0]   store_val;
  logic          cmp_ev;
  acf_flag_ctl_t flag_ctl;

  assign idx     = avs_address_in[7:2];
  assign req     = avs_read_in | avs_write_in;
  assign wr_go   = avs_write_in & ~wait_q;
  assign rd_go   = avs_read_in & ~wait_q;
  assign res_sel = is_res(idx);
  assign rs      = res_slot(idx);
  assign wd16    = avs_writedata_in[15:0];
  assign ffc     = ctl_q[CTL_FFC_BIT];
  assign cie     = ctl_q[CTL_CIE_BIT];

  assign cslot    = conv_in.slot;
  assign stored   = res_q[cslot];
  assign stored12 = right_justify_in ? stored[11:0]
                                     : stored[15:JUST_SHIFT];
  assign cmp_on   = slot_compare_enable_q[cslot];
  assign hit      = compare_higher_select_q[cslot] ? (conv_in.value > stored12)
                                   : (conv_in.value <= stored12);
  assign store_val = right_justify_in ? {4'h0, conv_in.value}
                                      : {conv_in.value, 4'h0};
  assign cmp_ev   = conv_in.valid & cmp_on & hit & cie;

  // flag set and clear sources
  always_comb begin
    flag_ctl = '0;
    if (conv_in.valid && (!cmp_on || hit)) begin
      flag_ctl.set = onehot16(cslot);
    end
    if (wr_go && idx == IDX_FLAGS && !ffc) begin
      flag_ctl.bus_clr = merge16(RST_REG, wd16,
                                 avs_byteenable_in);
    end else if (rd_go && res_sel && ffc && !slot_compare_enable_q[rs]) begin
      flag_ctl.bus_clr = onehot16(rs);
    end else if (wr_go && res_sel && ffc && slot_compare_enable_q[rs]) begin
      flag_ctl.bus_clr = onehot16(rs);
    end
    flag_ctl.seq_clr = wr_go && idx == IDX_SEQ;
  end

  acf_flag_bank u_flags (
    .ref_clk_in  (ref_clk_in),
    .srst_in     (srst_in),
    .flag_ctl_in (flag_ctl),
    .flags_out   (conversion_done_flags_out)
  );

  // bus handshake and read data
  always_comb begin
    next_wait  = ~(req & wait_q);
    next_rdata = avs_readdata_out;
    next_start = wr_go && idx == IDX_SEQ;
    next_abort = wr_go && (idx == IDX_COMPARE_HIGHER_SELECT
                        || idx == IDX_SLOT_COMPARE_ENABLE);
    if (avs_read_in && wait_q) begin
      next_rdata = RST_RDATA;
      if (idx == IDX_CTL) begin
        next_rdata[15:0] = ctl_q;
      end else if (idx == IDX_SLOT_COMPARE_ENABLE) begin
        next_rdata[15:0] = slot_compare_enable_q;
      end else if (idx == IDX_FLAGS) begin
        next_rdata[15:0] = conversion_done_flags_out;
      end else if (idx == IDX_DIEN) begin
        next_rdata[15:0] = digital_input_buffer_enable_out;
      end else if (idx == IDX_COMPARE_HIGHER_SELECT) begin
        next_rdata[15:0] = compare_higher_select_q;
      end else if (res_sel) begin
        next_rdata[15:0] = res_q[rs];
      end else if (idx == IDX_ISTAT) begin
        next_rdata[15:0] = stat_q;
      end else if (idx == IDX_IMASK) begin
        next_rdata[15:0] = mask_q;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      avs_waitrequest_out <= RST_WAIT;
      wait_q              <= RST_WAIT;
      avs_readdata_out    <= RST_RDATA;
      seq_start_out       <= 1'b0;
      seq_abort_out       <= 1'b0;
    end else begin
      avs_waitrequest_out <= next_wait;
      wait_q              <= next_wait;
      avs_readdata_out    <= next_rdata;
      seq_start_out       <= next_start;
      seq_abort_out       <= next_abort;
    end
  end

  // control, compare and result registers
  always_comb begin
    next_ctl   = ctl_q;
    next_slot_compare_enable  = slot_compare_enable_q;
    next_compare_higher_select = compare_higher_select_q;
    next_dien  = digital_input_buffer_enable_out;
    next_mask  = mask_q;
    for (int i = 0; i < SLOTS; i++) begin
      next_res[i] = res_q[i];
    end
    if (wr_go) begin
      if (idx == IDX_CTL) begin
        next_ctl = merge16(ctl_q, wd16, avs_byteenable_in) & CTL_MASK;
      end else if (idx == IDX_SLOT_COMPARE_ENABLE) begin
        next_slot_compare_enable = merge16(slot_compare_enable_q, wd16, avs_byteenable_in);
      end else if (idx == IDX_DIEN) begin
        next_dien = merge16(digital_input_buffer_enable_out, wd16,
                            avs_byteenable_in);
      end else if (idx == IDX_COMPARE_HIGHER_SELECT) begin
        next_compare_higher_select = merge16(compare_higher_select_q, wd16, avs_byteenable_in);
      end else if (res_sel) begin
        next_res[rs] = merge16(res_q[rs], wd16, avs_byteenable_in);
      end else if (idx == IDX_IMASK) begin
        next_mask = merge16(mask_q, wd16, avs_byteenable_in)
                  & IRQ_MASK_W;
      end
    end
    if (conv_in.valid && !cmp_on) begin
      next_res[cslot] = store_val;
    end
  end

  // interrupt status, set beats write-one clear
  always_comb begin
    next_stat = stat_q;
    if (wr_go && idx == IDX_ISTAT) begin
      next_stat = stat_q & ~merge16(RST_REG, wd16, avs_byteenable_in);
    end
    next_stat[IRQ_CMP_BIT]  = next_stat[IRQ_CMP_BIT] | cmp_ev;
    next_stat[IRQ_DONE_BIT] = next_stat[IRQ_DONE_BIT]
                            | (|flag_ctl.set);
    next_irq = |(next_stat & next_mask);
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      ctl_q   <= RST_REG;
      slot_compare_enable_q  <= RST_REG;
      compare_higher_select_q <= RST_REG;
      stat_q  <= RST_REG;
      mask_q  <= RST_REG;
      irq_out <= 1'b0;
      digital_input_buffer_enable_out <= RST_REG;
      for (int i = 0; i < SLOTS; i++) begin
        res_q[i] <= RST_REG;
      end
    end else begin
      ctl_q   <= next_ctl;
      slot_compare_enable_q  <= next_slot_compare_enable;
      compare_higher_select_q <= next_compare_higher_select;
      stat_q  <= next_stat;
      mask_q  <= next_mask;
      irq_out <= next_irq;
      digital_input_buffer_enable_out <= next_dien;
      for (int i = 0; i < SLOTS; i++) begin
        res_q[i] <= next_res[i];
      end
    end
  end

  // checks
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (srst_in);

  set_on_done_a: assert property (
    conv_in.valid && (!cmp_on || hit) && !flag_ctl.seq_clr
    |=> conversion_done_flags_out[$past(cslot)])
    else $error("done flag not set after conversion");

  ninth_lands_a: assert property (
    conv_in.valid && cslot == 4'h8 && !cmp_on && !flag_ctl.seq_clr
    |=> conversion_done_flags_out[8] && res_q[8] == $past(store_val))
    else $error("slot 8 flag or result wrong");

  cmp_gate_a: assert property (
    conv_in.valid && cmp_on && !hit && !flag_ctl.seq_clr
    && !conversion_done_flags_out[cslot]
    |=> !conversion_done_flags_out[$past(cslot)])
    else $error("flag set on false compare");

  cmp_irq_a: assert property (
    cmp_ev && mask_q[IRQ_CMP_BIT]
    |=> stat_q[IRQ_CMP_BIT] ##1 irq_out)
    else $error("compare irq not raised");

  keep_cmp_a: assert property (
    conv_in.valid && cmp_on && !(wr_go && res_sel)
    |=> res_q[$past(cslot)] == $past(stored))
    else $error("compare value overwritten");

  seq_clear_a: assert property (
    flag_ctl.seq_clr |=> conversion_done_flags_out == RST_REG)
    else $error("sequence start left flags set");

  w1c_flag_a: assert property (
    wr_go && idx == IDX_FLAGS && !ffc && avs_byteenable_in == 4'hF
    && flag_ctl.set == RST_REG
    |=> (conversion_done_flags_out & $past(wd16)) == RST_REG
    && (conversion_done_flags_out & ~$past(wd16))
       == ($past(conversion_done_flags_out) & ~$past(wd16)))
    else $error("write-one clear wrong");

  read_clr_a: assert property (
    rd_go && res_sel && ffc && !slot_compare_enable_q[rs] && !flag_ctl.set[rs]
    |=> !conversion_done_flags_out[$past(rs)])
    else $error("result read did not clear flag");

  write_clr_a: assert property (
    wr_go && res_sel && ffc && slot_compare_enable_q[rs] && !flag_ctl.set[rs]
    |=> !conversion_done_flags_out[$past(rs)])
    else $error("result write did not clear flag");

  set_wins_a: assert property (
    (flag_ctl.set & flag_ctl.bus_clr) != RST_REG && !flag_ctl.seq_clr
    |=> (conversion_done_flags_out & $past(flag_ctl.set))
        == $past(flag_ctl.set))
    else $error("clear won over set");

  dien_load_a: assert property (
    wr_go && idx == IDX_DIEN && avs_byteenable_in == 4'hF
    |=> digital_input_buffer_enable_out == $past(wd16))
    else $error("input enable not loaded");

  dien_hold_a: assert property (
    !(wr_go && idx == IDX_DIEN)
    |=> $stable(digital_input_buffer_enable_out))
    else $error("input enable changed by itself");

  abort_a: assert property (
    wr_go && idx == IDX_COMPARE_HIGHER_SELECT |=> seq_abort_out ##1 !seq_abort_out)
    else $error("no abort pulse after direction write");

  higher_strict_a: assert property (
    conv_in.valid && cmp_on && compare_higher_select_q[cslot]
    && conv_in.value == stored12 && !flag_ctl.seq_clr
    && !conversion_done_flags_out[cslot]
    |=> !conversion_done_flags_out[$past(cslot)])
    else $error("equal value flagged as higher");

  flag_read_a: assert property (
    rd_go && idx == IDX_FLAGS && flag_ctl.set == RST_REG
    && flag_ctl.bus_clr == RST_REG && !flag_ctl.seq_clr
    |=> $stable(conversion_done_flags_out))
    else $error("flag read changed flags");

  cmp_hit_c: cover property (conv_in.valid && cmp_on && hit);
  clash_c:   cover property ((flag_ctl.set & flag_ctl.bus_clr) != 0);
  seq_c:     cover property (flag_ctl.seq_clr && flag_ctl.set != 0);
  irq_c:     cover property ($rose(irq_out));
endmodule
`default_nettype wire

// *** test/tb_acf_top.sv ***
// Purpose: self-checking bench for the conversion flag block
// Assumes: one wait state per bus access, rows run back to back
// Notes:   no random stimulus, all inputs driven by nba at posedge
`timescale 1ns/1ps
`default_nettype none
module tb_acf_top;
  import acf_pkg::*;
  typedef struct packed {
    logic [3:0]  slot;
    logic [11:0] val;
    logic        slot_compare_enable;
    logic        ht;
    logic        rj;
    logic [15:0] preset;
    logic        flag;
    logic [15:0] res;
  } acf_row_t;
  logic        ref_clk_in = 1'b0;
  logic        srst_in    = 1'b1;
  logic [7:0]  addr       = 8'h00;
  logic        rd_s       = 1'b0;
  logic        wr_s       = 1'b0;
  logic [31:0] wdata      = 32'h0000_0000;
  logic [31:0] rdata;
  logic        wait_s;
  acf_conv_t   conv       = '0;
  logic        rj         = 1'b1;
  logic        seq_start;
  logic        seq_abort;
  logic [15:0] flags;
  logic [15:0] dien;
  logic        irq;
  int          mismatches = 0;
  int          num_checks = 0;
  int          starts     = 0;
  int          aborts     = 0;
  int          a0;
  acf_row_t    rows [8] = '{
    '{4'h3, 12'hABC, 1'b0, 1'b0, 1'b1, 16'h0000, 1'b1, 16'h0ABC},
    '{4'h8, 12'h123, 1'b0, 1'b0, 1'b0, 16'h0000, 1'b1, 16'h1230},
    '{4'h2, 12'h800, 1'b1, 1'b0, 1'b1, 16'h0800, 1'b1, 16'h0800},
    '{4'h2, 12'h801, 1'b1, 1'b0, 1'b1, 16'h0800, 1'b0, 16'h0800},
    '{4'h2, 12'h801, 1'b1, 1'b1, 1'b1, 16'h0800, 1'b1, 16'h0800},
    '{4'h2, 12'h800, 1'b1, 1'b1, 1'b1, 16'h0800, 1'b0, 16'h0800},
    '{4'hF, 12'h7FF, 1'b1, 1'b1, 1'b0, 16'h8000, 1'b0, 16'h8000},
    '{4'hF, 12'hFFF, 1'b1, 1'b0, 1'b1, 16'h0FFE, 1'b0, 16'h0FFE}};

  acf_top dut_u (
    .ref_clk_in                      (ref_clk_in),
    .srst_in                         (srst_in),
    .avs_address_in                  (addr),
    .avs_read_in                     (rd_s),
    .avs_write_in                    (wr_s),
    .avs_writedata_in                (wdata),
    .avs_byteenable_in               (4'hF),
    .avs_readdata_out                (rdata),
    .avs_waitrequest_out             (wait_s),
    .conv_in                         (conv),
    .right_justify_in                (rj),
    .seq_start_out                   (seq_start),
    .seq_abort_out                   (seq_abort),
    .conversion_done_flags_out       (flags),
    .digital_input_buffer_enable_out (dien),
    .irq_out                         (irq)
  );

  always #50 ref_clk_in = ~ref_clk_in;

  always @(posedge ref_clk_in) begin
    if (seq_start === 1'b1) starts <= starts + 1;
    if (seq_abort === 1'b1) aborts <= aborts + 1;
  end

  task automatic chk(input string name, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bus(input logic w, input logic [5:0] idx,
                     input logic [15:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    addr  <= {idx, 2'b00};
    wdata <= {16'h0000, d};
    wr_s  <= w;
    rd_s  <= ~w;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (wait_s !== 1'b0 && n < 50);
    if (n >= 50) chk("bus ack", 32'h0, 32'h1);
    r = rdata;
    wr_s <= 1'b0;
    rd_s <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [15:0] d);
    logic [31:0] r;
    bus(1'b1, idx, d, r);
  endtask

  task automatic rchk(input string name, input logic [5:0] idx,
                      input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, idx, 16'h0000, r);
    chk(name, r, exp);
  endtask

  task automatic cv(input logic [3:0] s, input logic [11:0] v);
    @(posedge ref_clk_in);
    conv <= {1'b1, s, v};
    @(posedge ref_clk_in);
    conv.valid <= 1'b0;
  endtask

  task automatic collide(input logic [5:0] idx, input logic [15:0] d,
                         input logic [3:0] s);
    fork
      wr(idx, d);
      begin
        repeat (2) @(posedge ref_clk_in);
        conv <= {1'b1, s, 12'h001};
        @(posedge ref_clk_in);
        conv.valid <= 1'b0;
      end
    join
  endtask

  function automatic logic [5:0] ridx(input logic [3:0] s);
    return IDX_RES0 + {1'b0, s, 1'b0};
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk_in);
    mismatches++;
    summarize();
  end

  initial begin
    repeat (16) @(posedge ref_clk_in);
    srst_in <= 1'b0;
    foreach (rows[i]) begin
      rj <= rows[i].rj;
      wr(IDX_SEQ, 16'h0000);
      wr(IDX_SLOT_COMPARE_ENABLE, 16'(rows[i].slot_compare_enable) << rows[i].slot);
      wr(IDX_COMPARE_HIGHER_SELECT, 16'(rows[i].ht) << rows[i].slot);
      wr(ridx(rows[i].slot), rows[i].preset);
      cv(rows[i].slot, rows[i].val);
      rchk("flags", IDX_FLAGS, 16'(rows[i].flag) << rows[i].slot);
      rchk("result", ridx(rows[i].slot), {16'h0000, rows[i].res});
    end
    $display("test rows done");
    rj <= 1'b1;
    wr(IDX_SLOT_COMPARE_ENABLE, 16'h0000);
    a0 = starts;
    wr(IDX_SEQ, 16'h0000);
    cv(4'h1, 12'h011);
    cv(4'h4, 12'h044);
    repeat (2) @(posedge ref_clk_in);
    chk("start pulses", starts, a0 + 1);
    chk("flag port", flags, 16'h0012);
    wr(IDX_FLAGS, 16'h0000);
    rchk("flags w0", IDX_FLAGS, 16'h0012);
    rchk("flags reread", IDX_FLAGS, 16'h0012);
    wr(IDX_FLAGS, 16'h0002);
    rchk("flags w1c", IDX_FLAGS, 16'h0010);
    collide(IDX_FLAGS, 16'h0020, 4'h5);
    rchk("set over w1c", IDX_FLAGS, 16'h0030);
    collide(IDX_SEQ, 16'h0000, 4'h5);
    rchk("start over set", IDX_FLAGS, 16'h0000);
    $display("test flag clears done");
    wr(IDX_CTL, 16'h0001);
    wr(IDX_SLOT_COMPARE_ENABLE, 16'h0080);
    a0 = aborts;
    wr(IDX_COMPARE_HIGHER_SELECT, 16'h0080);
    repeat (2) @(posedge ref_clk_in);
    chk("abort pulses", aborts, a0 + 2);
    wr(ridx(4'h7), 16'h0000);
    wr(IDX_SEQ, 16'h0000);
    cv(4'h6, 12'h055);
    cv(4'h7, 12'h005);
    wr(IDX_FLAGS, 16'h00C0);
    rchk("fast w1c off", IDX_FLAGS, 16'h00C0);
    rchk("res6", ridx(4'h6), 32'h0000_0055);
    rchk("read clear", IDX_FLAGS, 16'h0080);
    rchk("res7 kept", ridx(4'h7), 32'h0000_0000);
    rchk("no read clear", IDX_FLAGS, 16'h0080);
    wr(ridx(4'h7), 16'h0000);
    rchk("write clear", IDX_FLAGS, 16'h0000);
    $display("test fast clear done");
    wr(IDX_CTL, 16'h0002);
    wr(IDX_IMASK, 16'h0001);
    cv(4'h7, 12'h005);
    repeat (3) @(posedge ref_clk_in);
    chk("irq up", irq, 1'b1);
    rchk("irq status", IDX_ISTAT, 32'h0000_0003);
    wr(IDX_IMASK, 16'h0000);
    repeat (3) @(posedge ref_clk_in);
    chk("irq masked", irq, 1'b0);
    wr(IDX_IMASK, 16'h0001);
    wr(IDX_ISTAT, 16'h0001);
    repeat (3) @(posedge ref_clk_in);
    chk("irq cleared", irq, 1'b0);
    $display("test irq done");
    wr(IDX_DIEN, 16'hA5C3);
    cv(4'h0, 12'h100);
    cv(4'h1, 12'h101);
    @(posedge ref_clk_in);
    chk("dien port", dien, 16'hA5C3);
    rchk("dien read", IDX_DIEN, 32'h0000_A5C3);
    rchk("unmapped", 6'h3F, 32'h0000_0000);
    $display("test enables done");
    srst_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    srst_in <= 1'b0;
    @(posedge ref_clk_in);
    chk("rst flags", flags, 16'h0000);
    chk("rst dien", dien, 16'h0000);
    chk("rst irq", irq, 1'b0);
    chk("rst wait", wait_s, RST_WAIT);
    rchk("rst ctl", IDX_CTL, RST_RDATA);
    rchk("rst slot_compare_enable", IDX_SLOT_COMPARE_ENABLE, RST_RDATA);
    rchk("rst compare_higher_select", IDX_COMPARE_HIGHER_SELECT, RST_RDATA);
    rchk("rst mask", IDX_IMASK, RST_RDATA);
    $display("test reset done");
    summarize();
  end
endmodule
`default_nettype wire
